// [verilog/clkgen_pkg.sv]
/*
 holds register offsets, field positions, reset values and timing counts
 of the slow and main clock generator control block.
 assumes an apb master with 32-bit data and a single 20 MHz clock.
*/
// Operation
// - at supply up both slow oscillators powered, only rc enabled and selected
// - slow source status shown in supply status and power status registers
// - crystal select runs pins, crystal enable, rc disable sequence glitch-free
// - once crystal selected software cannot go back to slow rc
// - slow crystal pins are pulled-up inputs until crystal selected
// - after reset main rc enabled at 4 MHz and selected as main clock
// - rc enable bit switches rc; clearing it clears rc stable flag
// - freq change clears rc stable, stops main clock until settled
// - rc stable flag raises interrupt when enabled
// - trim writes return to production values after every reset
// - per-frequency select bit applies user trim instead of production trim
// - user trim never applies to the currently running rc frequency; here it is taken at the next freq change or rc enable
// - measure restart starts measurement; ready then count readable
// - after reset main crystal disabled and not main source
// - clearing crystal enable clears crystal stable flag
// - crystal enable with startup loads 8-bit counter on slow clock div 8
// - counter at zero sets crystal stable; unmasked it interrupts
// - source select switches glitch-free; done flag interrupts when unmasked
// - main rc forced as main source at start and on wait entry
package clkgen_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] SUPPLY_CONTROL_OFS = 8'h00;
  localparam logic [7:0] SUPPLY_MODE_OFS    = 8'h04;
  localparam logic [7:0] SUPPLY_STATUS_OFS  = 8'h08;
  localparam logic [7:0] MAIN_OSC_OFS       = 8'h0C;
  localparam logic [7:0] MAIN_FREQ_OFS      = 8'h10;
  localparam logic [7:0] POWER_STATUS_OFS   = 8'h14;
  localparam logic [7:0] IRQ_ENABLE_OFS     = 8'h18;
  localparam logic [7:0] IRQ_DISABLE_OFS    = 8'h1C;
  localparam logic [7:0] IRQ_MASK_OFS       = 8'h20;
  localparam logic [7:0] RC_TRIM_OFS        = 8'h24;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int XTAL_SEL_BIT   = 3;
  localparam int BYPASS_BIT     = 20;
  localparam int SLOW_SRC_BIT   = 7;
  localparam int XT_EN_BIT      = 0;
  localparam int RC_EN_BIT      = 3;
  localparam int RC_FREQ_LSB    = 4;
  localparam int XT_ST_LSB      = 8;
  localparam int SRC_SEL_BIT    = 24;
  localparam int XT_STABLE_BIT  = 0;
  localparam int SRC_DONE_BIT   = 16;
  localparam int RC_STABLE_BIT  = 17;
  localparam int MEAS_RDY_BIT   = 16;
  localparam int MEAS_RST_BIT   = 20;
  localparam int TRIM_W         = 7;
  localparam int TRIM_MID_LSB   = 8;
  localparam int TRIM_HIGH_LSB  = 16;
  localparam int TRIM_SEL_LOW   = 7;
  localparam int TRIM_SEL_MID   = 15;
  localparam int TRIM_SEL_HIGH  = 23;

  ////////////////////////////////////////////////////////////////////////////
  // encodings, reset values, timing
  localparam logic [1:0] RC_FREQ_4  = 2'h0;
  localparam logic [1:0] RC_FREQ_8  = 2'h1;
  localparam logic [1:0] RC_FREQ_12 = 2'h2;
  localparam logic [1:0] RC_FREQ_RST = RC_FREQ_4;
  localparam logic [6:0] PROD_TRIM_LOW  = 7'h40;
  localparam logic [6:0] PROD_TRIM_MID  = 7'h40;
  localparam logic [6:0] PROD_TRIM_HIGH = 7'h40;
  localparam logic [2:0] SLOW_DIV_LAST  = 3'h7;
  localparam logic [3:0] MEAS_PERIODS   = 4'hF;
  localparam logic [7:0] RC_SETTLE_CYC  = 8'h04;
  localparam logic [1:0] SW_STEPS       = 2'h3;

  typedef struct packed {
    logic       xt_en;
    logic       rc_en;
    logic [1:0] rc_freq;
    logic [7:0] xt_startup;
    logic       src_sel;
  } main_osc_s;

  typedef enum logic [3:0] {
    SW_IDLE = 4'h1,
    SW_PINS = 4'h2,
    SW_XTAL = 4'h4,
    SW_DONE = 4'h8
  } slow_sw_e;

endpackage

// [verilog/clkgen_count.sv]
/*
 down counter with load and zero flag, used for settling periods.
 assumes the load and tick come from the same clock domain.
*/
module clkgen_count #(
  parameter int W = 8
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] value,
  input  wire logic         tick,
  // status
  output logic              zero,
  output logic              busy
);
  logic [W-1:0] count;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      busy  <= 1'b0;
    end else if (load) begin
      count <= value;
      busy  <= 1'b1;
    end else if (busy && tick) begin
      if (count == '0) begin
        busy <= 1'b0;
      end else begin
        count <= count - 1'b1;
      end
    end
  end

  assign zero = busy && tick && (count == '0);
endmodule

// [verilog/clkgen_ctrl.sv]
/*
 control logic of the slow and main clock generator with apb registers.
 assumes apb signals synchronous to REF_CLK, slow clock ticks given as a
 synchronous pulse, main clock edges given as a synchronous pulse.
*/
module clkgen_ctrl (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_N,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // system events
  input  wire logic        SLOW_TICK,
  input  wire logic        MAIN_TICK,
  input  wire logic        WAIT_ENTRY,
  // slow oscillator control
  output logic             SLOW_RC_ENABLE,
  output logic             SLOW_XTAL_ENABLE,
  output logic             SLOW_XTAL_POWER,
  output logic             SLOW_OSC_BYPASS,
  output logic             SLOW_PINS_TO_OSC,
  output logic             SLOW_SOURCE_XTAL,
  // main oscillator control and interrupt
  output logic             MAIN_RC_ENABLE,
  output logic [1:0]       MAIN_RC_FREQ_SEL,
  output logic [6:0]       MAIN_RC_TRIM,
  output logic             MAIN_XTAL_ENABLE,
  output logic             MAIN_PINS_TO_OSC,
  output logic             MAIN_SOURCE_XTAL,
  output logic             MAIN_CLOCK_GATE,
  output logic             IRQ
);
  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire wr = PSEL && PENABLE && PWRITE;
  wire rd = PSEL && PENABLE && !PWRITE;
  wire wr_sc  = wr && (PADDR == clkgen_pkg::SUPPLY_CONTROL_OFS);
  wire wr_sm  = wr && (PADDR == clkgen_pkg::SUPPLY_MODE_OFS);
  wire wr_mo  = wr && (PADDR == clkgen_pkg::MAIN_OSC_OFS);
  wire wr_mf  = wr && (PADDR == clkgen_pkg::MAIN_FREQ_OFS);
  wire wr_ie  = wr && (PADDR == clkgen_pkg::IRQ_ENABLE_OFS);
  wire wr_id  = wr && (PADDR == clkgen_pkg::IRQ_DISABLE_OFS);
  wire wr_tr  = wr && (PADDR == clkgen_pkg::RC_TRIM_OFS);
  wire rd_mf  = rd && (PADDR == clkgen_pkg::MAIN_FREQ_OFS);
  wire mapped = (PADDR[1:0] == 2'h0) && (PADDR <= clkgen_pkg::RC_TRIM_OFS);

  clkgen_pkg::main_osc_s mo;
  clkgen_pkg::main_osc_s wmo;
  assign wmo.xt_en      = PWDATA[clkgen_pkg::XT_EN_BIT];
  assign wmo.rc_en      = PWDATA[clkgen_pkg::RC_EN_BIT];
  assign wmo.rc_freq    = PWDATA[clkgen_pkg::RC_FREQ_LSB +: 2];
  assign wmo.xt_startup = PWDATA[clkgen_pkg::XT_ST_LSB +: 8];
  assign wmo.src_sel    = PWDATA[clkgen_pkg::SRC_SEL_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // slow clock source sequence
  clkgen_pkg::slow_sw_e slow_state;
  clkgen_pkg::slow_sw_e next_slow_state;
  logic bypass;
  wire  xtal_req = wr_sc && PWDATA[clkgen_pkg::XTAL_SEL_BIT];

  always_comb begin
    case (slow_state)
      clkgen_pkg::SW_IDLE: next_slow_state = xtal_req ?
                             clkgen_pkg::SW_PINS : clkgen_pkg::SW_IDLE;
      clkgen_pkg::SW_PINS: next_slow_state = clkgen_pkg::SW_XTAL;
      clkgen_pkg::SW_XTAL: next_slow_state = SLOW_TICK ?
                             clkgen_pkg::SW_DONE : clkgen_pkg::SW_XTAL;
      clkgen_pkg::SW_DONE: next_slow_state = clkgen_pkg::SW_DONE;
      default:             next_slow_state = clkgen_pkg::SW_IDLE;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      slow_state <= clkgen_pkg::SW_IDLE;
      bypass     <= 1'b0;
    end else begin
      slow_state <= next_slow_state;
      if (wr_sm) begin
        bypass <= PWDATA[clkgen_pkg::BYPASS_BIT];
      end
    end
  end

  wire slow_xtal = (slow_state == clkgen_pkg::SW_DONE);
  assign SLOW_XTAL_POWER  = 1'b1;
  assign SLOW_PINS_TO_OSC = (slow_state != clkgen_pkg::SW_IDLE);
  assign SLOW_XTAL_ENABLE = SLOW_PINS_TO_OSC &&
                            (slow_state != clkgen_pkg::SW_PINS);
  assign SLOW_RC_ENABLE   = !slow_xtal;
  assign SLOW_SOURCE_XTAL = slow_xtal;
  assign SLOW_OSC_BYPASS  = bypass;

  ////////////////////////////////////////////////////////////////////////////
  // main oscillator register
  logic [2:0] slow_div;
  wire        div_tick = SLOW_TICK && (slow_div == clkgen_pkg::SLOW_DIV_LAST);
  wire        rc_freq_chg = wr_mo && mo.rc_en && wmo.rc_en &&
                            (wmo.rc_freq != mo.rc_freq);
  wire        rc_on_chg   = wr_mo && (wmo.rc_en != mo.rc_en);
  wire        xt_start    = wr_mo && wmo.xt_en && !mo.xt_en;
  wire        src_chg     = (wr_mo && (wmo.src_sel != mo.src_sel)) ||
                            (WAIT_ENTRY && mo.src_sel);
  wire        rc_zero;
  wire        rc_busy;
  wire        xt_zero;
  wire        xt_busy;
  logic       rc_stable;
  logic       xt_stable;
  logic       src_done;
  logic [1:0] sw_cnt;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mo.xt_en      <= 1'b0;
      mo.rc_en      <= 1'b1;
      mo.rc_freq    <= clkgen_pkg::RC_FREQ_RST;
      mo.xt_startup <= 8'h00;
      mo.src_sel    <= 1'b0;
      slow_div      <= 3'h0;
    end else begin
      if (SLOW_TICK) begin
        slow_div <= slow_div + 3'h1;
      end
      if (WAIT_ENTRY) begin
        mo.src_sel <= 1'b0;
      end else if (wr_mo) begin
        mo.src_sel <= wmo.src_sel;
      end
      if (wr_mo) begin
        mo.xt_en      <= wmo.xt_en;
        mo.rc_en      <= wmo.rc_en;
        mo.xt_startup <= wmo.xt_startup;
        if (!rc_on_chg) begin
          mo.rc_freq <= wmo.rc_freq;
        end
      end
    end
  end

  clkgen_count #(.W(8)) u_rc_settle (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .load  (rc_freq_chg || (rc_on_chg && wmo.rc_en)),
    .value (clkgen_pkg::RC_SETTLE_CYC),
    .tick  (1'b1),
    .zero  (rc_zero),
    .busy  (rc_busy)
  );

  clkgen_count #(.W(8)) u_xt_start (
    .clk   (REF_CLK),
    .rst_n (RST_N),
    .load  (xt_start),
    .value (wmo.xt_startup),
    .tick  (div_tick),
    .zero  (xt_zero),
    .busy  (xt_busy)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status flags, a restart or disable outranks a settle ending with it
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rc_stable <= 1'b1;
      xt_stable <= 1'b0;
      src_done  <= 1'b1;
      sw_cnt    <= 2'h0;
    end else begin
      if (rc_freq_chg || rc_on_chg) begin
        rc_stable <= 1'b0;
      end else if (rc_zero) begin
        rc_stable <= mo.rc_en;
      end
      if (xt_start || (wr_mo && !wmo.xt_en)) begin
        xt_stable <= 1'b0;
      end else if (xt_zero && mo.xt_en) begin
        xt_stable <= 1'b1;
      end
      if (src_chg) begin
        src_done <= 1'b0;
        sw_cnt   <= clkgen_pkg::SW_STEPS;
      end else if (!src_done && MAIN_TICK) begin
        if (sw_cnt == 2'h0) begin
          src_done <= 1'b1;
        end else begin
          sw_cnt <= sw_cnt - 2'h1;
        end
      end
    end
  end

  assign MAIN_RC_ENABLE   = mo.rc_en;
  assign MAIN_RC_FREQ_SEL = mo.rc_freq;
  assign MAIN_XTAL_ENABLE = mo.xt_en;
  assign MAIN_PINS_TO_OSC = mo.xt_en;
  assign MAIN_SOURCE_XTAL = mo.src_sel && src_done;
  assign MAIN_CLOCK_GATE  = mo.src_sel ? xt_stable : (rc_stable && !rc_busy);

  ////////////////////////////////////////////////////////////////////////////
  // interrupt mask
  logic [31:0] imask;
  wire  [31:0] status;
  assign status = ({31'h0, xt_stable} << clkgen_pkg::XT_STABLE_BIT) |
                  ({31'h0, src_done} << clkgen_pkg::SRC_DONE_BIT) |
                  ({31'h0, rc_stable} << clkgen_pkg::RC_STABLE_BIT) |
                  ({31'h0, slow_xtal} << clkgen_pkg::SLOW_SRC_BIT);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      imask <= 32'h0;
    end else if (wr_ie) begin
      imask <= imask | PWDATA;
    end else if (wr_id) begin
      imask <= imask & ~PWDATA;
    end
  end

  assign IRQ = |(status & imask & 32'h0003_0001);

  ////////////////////////////////////////////////////////////////////////////
  // trim register, reset restores production values
  logic [6:0] trim_low;
  logic [6:0] trim_mid;
  logic [6:0] trim_high;
  logic [2:0] trim_sel;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      trim_low  <= clkgen_pkg::PROD_TRIM_LOW;
      trim_mid  <= clkgen_pkg::PROD_TRIM_MID;
      trim_high <= clkgen_pkg::PROD_TRIM_HIGH;
      trim_sel  <= 3'h0;
    end else if (wr_tr) begin
      trim_low  <= PWDATA[0 +: clkgen_pkg::TRIM_W];
      trim_mid  <= PWDATA[clkgen_pkg::TRIM_MID_LSB +: clkgen_pkg::TRIM_W];
      trim_high <= PWDATA[clkgen_pkg::TRIM_HIGH_LSB +: clkgen_pkg::TRIM_W];
      trim_sel  <= {PWDATA[clkgen_pkg::TRIM_SEL_HIGH],
                    PWDATA[clkgen_pkg::TRIM_SEL_MID],
                    PWDATA[clkgen_pkg::TRIM_SEL_LOW]};
    end
  end

  // trim latched for the running setting, refreshed only while settling after a freq change or rc enable
  logic [6:0] trim_run;
  wire  [6:0] trim_pick =
    (mo.rc_freq == clkgen_pkg::RC_FREQ_8) ?
      (trim_sel[1] ? trim_mid : clkgen_pkg::PROD_TRIM_MID) :
    (mo.rc_freq == clkgen_pkg::RC_FREQ_12) ?
      (trim_sel[2] ? trim_high : clkgen_pkg::PROD_TRIM_HIGH) :
      (trim_sel[0] ? trim_low : clkgen_pkg::PROD_TRIM_LOW);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      trim_run <= clkgen_pkg::PROD_TRIM_LOW;
    end else if (rc_busy) begin
      trim_run <= trim_pick;
    end
  end
  assign MAIN_RC_TRIM = trim_run;

  ////////////////////////////////////////////////////////////////////////////
  // frequency measurement
  logic        meas_run;
  logic        meas_rdy;
  logic [15:0] meas_cnt;
  logic [3:0]  meas_per;
  wire meas_start = (wr_mf && PWDATA[clkgen_pkg::MEAS_RST_BIT]) || src_chg ||
                    rc_zero || (xt_zero && mo.xt_en);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      meas_run <= 1'b0;
      meas_rdy <= 1'b0;
      meas_cnt <= 16'h0;
      meas_per <= 4'h0;
    end else if (meas_start) begin
      meas_run <= 1'b1;
      meas_rdy <= 1'b0;
      meas_cnt <= 16'h0;
      meas_per <= 4'h0;
    end else if (meas_run) begin
      if (MAIN_TICK) begin
        meas_cnt <= meas_cnt + 16'h1;
      end
      if (SLOW_TICK) begin
        meas_per <= meas_per + 4'h1;
        if (meas_per == clkgen_pkg::MEAS_PERIODS) begin
          meas_run <= 1'b0;
          meas_rdy <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux
  logic [31:0] rdata;
  always_comb begin
    case (PADDR)
      clkgen_pkg::SUPPLY_MODE_OFS:
        rdata = {11'h0, bypass, 20'h0};
      clkgen_pkg::SUPPLY_STATUS_OFS:
        rdata = {24'h0, slow_xtal, 7'h0};
      clkgen_pkg::MAIN_OSC_OFS:
        rdata = {7'h0, mo.src_sel, 8'h0, mo.xt_startup, 2'h0, mo.rc_freq,
                 mo.rc_en, 2'h0, mo.xt_en};
      clkgen_pkg::MAIN_FREQ_OFS:
        rdata = {15'h0, meas_rdy, meas_cnt};
      clkgen_pkg::POWER_STATUS_OFS: rdata = status;
      clkgen_pkg::IRQ_MASK_OFS:     rdata = imask;
      clkgen_pkg::RC_TRIM_OFS:
        rdata = {8'h0, trim_sel[2], trim_high, trim_sel[1], trim_mid,
                 trim_sel[0], trim_low};
      default:                      rdata = 32'h0;
    endcase
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      PRDATA <= 32'h0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      PRDATA <= rdata;
    end
  end

  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_slow_lock;
    @(posedge REF_CLK) disable iff (!RST_N)
    slow_xtal |=> slow_xtal;
  endproperty
  a_slow_lock: assert property (p_slow_lock)
    else $error("slow source returned to rc");

  property p_pins;
    @(posedge REF_CLK) disable iff (!RST_N)
    (slow_state == clkgen_pkg::SW_IDLE) && xtal_req |=> SLOW_PINS_TO_OSC
      && !SLOW_XTAL_ENABLE ##1 SLOW_XTAL_ENABLE && SLOW_RC_ENABLE;
  endproperty
  a_pins: assert property (p_pins)
    else $error("slow switch order wrong");

  property p_rc_off;
    @(posedge REF_CLK) disable iff (!RST_N)
    wr_mo && !wmo.rc_en && mo.rc_en |=> !rc_stable;
  endproperty
  a_rc_off: assert property (p_rc_off)
    else $error("rc stable kept after disable");

  property p_freq;
    @(posedge REF_CLK) disable iff (!RST_N)
    rc_freq_chg |=> !rc_stable && (mo.src_sel || !MAIN_CLOCK_GATE);
  endproperty
  a_freq: assert property (p_freq)
    else $error("freq change did not stop clock");

  property p_xt_off;
    @(posedge REF_CLK) disable iff (!RST_N)
    wr_mo && !wmo.xt_en |=> !xt_stable;
  endproperty
  a_xt_off: assert property (p_xt_off)
    else $error("xtal stable kept after disable");

  property p_xt_done;
    @(posedge REF_CLK) disable iff (!RST_N)
    xt_zero && mo.xt_en && !wr_mo && !wr_id &&
      imask[clkgen_pkg::XT_STABLE_BIT] |=> IRQ;
  endproperty
  a_xt_done: assert property (p_xt_done)
    else $error("xtal stable irq missing");

  property p_src;
    @(posedge REF_CLK) disable iff (!RST_N)
    src_chg |=> !src_done;
  endproperty
  a_src: assert property (p_src)
    else $error("source done not cleared");

  property p_wait;
    @(posedge REF_CLK) disable iff (!RST_N)
    WAIT_ENTRY |=> !mo.src_sel;
  endproperty
  a_wait: assert property (p_wait)
    else $error("wait entry left xtal selected");

  property p_meas;
    @(posedge REF_CLK) disable iff (!RST_N)
    meas_start |=> meas_run && !meas_rdy;
  endproperty
  a_meas: assert property (p_meas)
    else $error("measurement not restarted");

  property p_rd;
    @(posedge REF_CLK) disable iff (!RST_N)
    rd_mf |-> PRDATA[clkgen_pkg::MEAS_RDY_BIT] == $past(meas_rdy);
  endproperty
  a_rd: assert property (p_rd)
    else $error("ready read mismatch");
endmodule

// [sim/osc_model.sv]
/*
 behavioural oscillators on the far side of the clock generator.
 assumes control levels come from the design in the REF_CLK domain.
*/
module osc_model #(
  parameter int SP = 4
) (
  // clock and reset
  input  wire logic REF_CLK,
  input  wire logic RST_N,
  // oscillator control
  input  wire logic MAIN_CLOCK_GATE,
  input  wire logic MAIN_RC_ENABLE,
  input  wire logic MAIN_XTAL_ENABLE,
  input  wire logic MAIN_SOURCE_XTAL,
  // clock events
  output logic      SLOW_TICK,
  output logic      MAIN_TICK
);
  timeunit 1ns;
  timeprecision 1ns;
  int   div;
  logic ph;
  wire  run = MAIN_CLOCK_GATE &
              (MAIN_SOURCE_XTAL ? MAIN_XTAL_ENABLE : MAIN_RC_ENABLE);
  // slow clock runs free, main clock edge every other cycle while running
  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      div <= 0;
      ph <= 1'b0;
    end else begin
      div <= (div == SP - 1) ? 0 : div + 1;
      ph <= ~ph;
    end
  end
  assign SLOW_TICK = (div == SP - 1);
  assign MAIN_TICK = run & ph;
endmodule

// [sim/slow_and_main_clock_generator_tb.sv]
/*
 self-checking bench of the clock generator control registers over apb.
 assumes the oscillator model answers slow and main clock events.
*/
module slow_and_main_clock_generator_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SP = 4;
  logic REF_CLK, RST_N, PSEL, PENABLE, PWRITE, WAIT_ENTRY;
  logic [7:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd, tw;
  logic PREADY, PSLVERR, SLOW_TICK, MAIN_TICK, er;
  logic SLOW_RC_ENABLE, SLOW_XTAL_ENABLE, SLOW_XTAL_POWER, SLOW_OSC_BYPASS;
  logic SLOW_PINS_TO_OSC, SLOW_SOURCE_XTAL, MAIN_RC_ENABLE, MAIN_XTAL_ENABLE;
  logic MAIN_PINS_TO_OSC, MAIN_SOURCE_XTAL, MAIN_CLOCK_GATE, IRQ;
  logic [1:0] MAIN_RC_FREQ_SEL;
  logic [6:0] MAIN_RC_TRIM;
  int fails, checked, n, st;
  clkgen_ctrl clkgen_ctrl_inst (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
    .SLOW_TICK(SLOW_TICK), .MAIN_TICK(MAIN_TICK), .WAIT_ENTRY(WAIT_ENTRY),
    .SLOW_RC_ENABLE(SLOW_RC_ENABLE), .SLOW_XTAL_ENABLE(SLOW_XTAL_ENABLE),
    .SLOW_XTAL_POWER(SLOW_XTAL_POWER), .SLOW_OSC_BYPASS(SLOW_OSC_BYPASS),
    .SLOW_PINS_TO_OSC(SLOW_PINS_TO_OSC), .SLOW_SOURCE_XTAL(SLOW_SOURCE_XTAL),
    .MAIN_RC_ENABLE(MAIN_RC_ENABLE), .MAIN_RC_FREQ_SEL(MAIN_RC_FREQ_SEL),
    .MAIN_RC_TRIM(MAIN_RC_TRIM), .MAIN_XTAL_ENABLE(MAIN_XTAL_ENABLE),
    .MAIN_PINS_TO_OSC(MAIN_PINS_TO_OSC), .MAIN_SOURCE_XTAL(MAIN_SOURCE_XTAL),
    .MAIN_CLOCK_GATE(MAIN_CLOCK_GATE), .IRQ(IRQ));
  osc_model #(.SP(SP)) osc_model_inst (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .MAIN_CLOCK_GATE(MAIN_CLOCK_GATE), .MAIN_RC_ENABLE(MAIN_RC_ENABLE),
    .MAIN_XTAL_ENABLE(MAIN_XTAL_ENABLE), .MAIN_SOURCE_XTAL(MAIN_SOURCE_XTAL),
    .SLOW_TICK(SLOW_TICK), .MAIN_TICK(MAIN_TICK));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge REF_CLK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic poll(input logic [7:0] a, input int b, input logic v,
                      input int mx);
    n = 0;
    do begin apb(1'b0, a, 0); n++; end while (rd[b] !== v && n < mx);
    chk(rd[b], v);
  endtask
  function automatic logic [31:0] mo(logic x, logic r, logic [1:0] f,
                                     logic [7:0] s, logic c);
    return {7'h0, c, 8'h0, s, 2'h0, f, r, 2'h0, x};
  endfunction
  function automatic logic [6:0] et(logic [1:0] f, logic [31:0] t);
    int l;
    l = 8 * f;
    return t[l+7] ? t[l+:7] : (f == 0 ? clkgen_pkg::PROD_TRIM_LOW :
           f == 1 ? clkgen_pkg::PROD_TRIM_MID : clkgen_pkg::PROD_TRIM_HIGH);
  endfunction
  task automatic stop_test();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge REF_CLK);
    fails++;
    stop_test();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    RST_N = 1'b0; PSEL = 1'b0; PENABLE = 1'b0; PWRITE = 1'b0;
    PADDR = 8'h00; PWDATA = 32'h0; WAIT_ENTRY = 1'b0;
    void'($urandom(32'h8d4a));
    repeat (16) @(posedge REF_CLK);
    RST_N <= 1'b1;
    @(negedge REF_CLK);
    chk({SLOW_RC_ENABLE, SLOW_XTAL_ENABLE, SLOW_XTAL_POWER}, 3'h5);
    chk({SLOW_PINS_TO_OSC, SLOW_SOURCE_XTAL}, 2'h0);
    chk({MAIN_RC_ENABLE, MAIN_RC_FREQ_SEL}, 3'h4);
    chk({MAIN_XTAL_ENABLE, MAIN_SOURCE_XTAL}, 2'h0);
    apb(1'b0, clkgen_pkg::POWER_STATUS_OFS, 0);
    chk(rd[17:16], 2'h3);
    apb(1'b0, clkgen_pkg::RC_TRIM_OFS, 0);
    chk(rd, 32'h00404040);
    $display("test reset done");
    tw = ($urandom & 32'h007F7F7F) | 32'h00808080;
    apb(1'b1, clkgen_pkg::RC_TRIM_OFS, tw);
    for (int f = 1; f < 4; f++) begin
      apb(1'b1, clkgen_pkg::MAIN_OSC_OFS, mo(0, 1, f % 3, 0, 0));
      @(negedge REF_CLK);
      chk({MAIN_CLOCK_GATE, MAIN_RC_FREQ_SEL}, f % 3);
      apb(1'b0, clkgen_pkg::POWER_STATUS_OFS, 0);
      chk(rd[17], 1'b0);
      poll(clkgen_pkg::POWER_STATUS_OFS, 17, 1'b1, 40);
      chk({MAIN_CLOCK_GATE, MAIN_RC_TRIM}, {1'b1, et(f % 3, tw)});
    end
    apb(1'b1, clkgen_pkg::RC_TRIM_OFS, tw ^ 32'h15);
    repeat (2) @(negedge REF_CLK);
    chk(MAIN_RC_TRIM, et(0, tw));
    apb(1'b1, clkgen_pkg::IRQ_ENABLE_OFS, 32'h00020000);
    @(negedge REF_CLK);
    chk(IRQ, 1'b1);
    apb(1'b1, clkgen_pkg::IRQ_DISABLE_OFS, 32'h00020000);
    apb(1'b0, clkgen_pkg::IRQ_MASK_OFS, 0);
    chk({rd, IRQ}, 33'h0);
    apb(1'b1, clkgen_pkg::MAIN_OSC_OFS, mo(0, 0, 0, 0, 0));
    apb(1'b0, clkgen_pkg::POWER_STATUS_OFS, 0);
    chk({rd[17], MAIN_RC_ENABLE}, 2'h0);
    apb(1'b1, clkgen_pkg::MAIN_OSC_OFS, mo(0, 1, 0, 0, 0));
    poll(clkgen_pkg::POWER_STATUS_OFS, 17, 1'b1, 40);
    $display("test rc done");
    st = 1 + $urandom % 3;
    apb(1'b1, clkgen_pkg::IRQ_ENABLE_OFS, 32'h1);
    apb(1'b1, clkgen_pkg::MAIN_OSC_OFS, mo(1, 1, 0, st, 0));
    apb(1'b0, clkgen_pkg::POWER_STATUS_OFS, 0);
    chk({rd[0], IRQ, MAIN_PINS_TO_OSC, MAIN_XTAL_ENABLE}, 4'h3);
    poll(clkgen_pkg::POWER_STATUS_OFS, 0, 1'b1, (st + 2) * 8 * SP);
    chk(3*n >= 8*SP*st && 3*n <= 8*SP*(st+1) + 1, 1'b1);
    @(negedge REF_CLK);
    chk(IRQ, 1'b1);
    apb(1'b1, clkgen_pkg::IRQ_DISABLE_OFS, 32'h1);
    apb(1'b1, clkgen_pkg::MAIN_OSC_OFS, mo(1, 1, 0, st, 1));
    apb(1'b0, clkgen_pkg::POWER_STATUS_OFS, 0);
    chk(rd[16], 1'b0);
    poll(clkgen_pkg::POWER_STATUS_OFS, 16, 1'b1, 40);
    chk(MAIN_SOURCE_XTAL, 1'b1);
    apb(1'b1, clkgen_pkg::IRQ_ENABLE_OFS, 32'h00010000);
    @(negedge REF_CLK);
    chk(IRQ, 1'b1);
    apb(1'b1, clkgen_pkg::IRQ_DISABLE_OFS, 32'h00010000);
    apb(1'b1, clkgen_pkg::MAIN_FREQ_OFS, 32'h00100000);
    apb(1'b0, clkgen_pkg::MAIN_FREQ_OFS, 0);
    chk(rd[16], 1'b0);
    poll(clkgen_pkg::MAIN_FREQ_OFS, 16, 1'b1, 100);
    apb(1'b0, clkgen_pkg::MAIN_FREQ_OFS, 0);
    chk(rd[15:0] >= 8 * SP - 2 && rd[15:0] <= 8 * SP + 2, 1'b1);
    @(posedge REF_CLK) WAIT_ENTRY <= 1'b1;
    @(posedge REF_CLK) WAIT_ENTRY <= 1'b0;
    n = 0;
    while (MAIN_SOURCE_XTAL !== 1'b0 && n < 40) begin
      @(negedge REF_CLK);
      n++;
    end
    chk(MAIN_SOURCE_XTAL, 1'b0);
    apb(1'b1, clkgen_pkg::MAIN_OSC_OFS, mo(0, 1, 0, 0, 0));
    apb(1'b0, clkgen_pkg::POWER_STATUS_OFS, 0);
    chk({rd[0], MAIN_XTAL_ENABLE}, 2'h0);
    apb(1'b1, clkgen_pkg::MAIN_OSC_OFS, mo(0, 0, 0, 0, 0));
    @(negedge REF_CLK);
    chk({MAIN_RC_ENABLE, MAIN_XTAL_ENABLE, MAIN_CLOCK_GATE}, 3'h0);
    $display("test main xtal done");
    apb(1'b1, clkgen_pkg::SUPPLY_MODE_OFS, 32'h00100000);
    apb(1'b1, clkgen_pkg::SUPPLY_CONTROL_OFS, 32'h8);
    poll(clkgen_pkg::SUPPLY_STATUS_OFS, 7, 1'b1, 40);
    chk({SLOW_OSC_BYPASS, SLOW_PINS_TO_OSC, SLOW_XTAL_ENABLE}, 3'h7);
    apb(1'b1, clkgen_pkg::SUPPLY_CONTROL_OFS, 32'h0);
    apb(1'b0, clkgen_pkg::POWER_STATUS_OFS, 0);
    chk({rd[7], SLOW_RC_ENABLE, SLOW_SOURCE_XTAL}, 3'h5);
    apb(1'b0, 8'h28, 0);
    chk({er, rd}, 33'h100000000);
    $display("test slow and bus done");
    RST_N <= 1'b0;
    repeat (2) @(posedge REF_CLK);
    RST_N <= 1'b1;
    apb(1'b0, clkgen_pkg::RC_TRIM_OFS, 0);
    chk(rd, 32'h00404040);
    $display("test second reset done");
    stop_test();
  end
endmodule
